/* File: hdl/nos_pkg.sv */
// constants, types and register map of the nand otp / multi-plane sequencing host
// Contract
// RULE1: column-input command repeats until program confirm
// RULE2: otp page address only 02h to 1Eh
// RULE3: feature 90h value 03h enters protect mode
// RULE4: protect: program setup, zero address, zero data
// RULE5: protected otp area never programs again
// RULE6: protected program shows only short busy
// RULE7: otp mode allows only plain status read
// RULE8: read status bit 0 after otp operation
// RULE9: otp read: setup, five addresses, confirm
// RULE10: otp pages readable whether protected or not
// RULE11: no cached page reads in otp mode
// RULE12: otp read busy for array read time
// RULE13: random output within page, sequential strobes
// RULE14: two-plane operations all of one kind
// RULE15: two-plane fail needs enhanced status per plane; here one 78h command clears the need
// RULE16: plane addresses share die, page; differ plane
// RULE17: new operation allowed on idle die
// RULE18: no interleave after reset/config until ready
// RULE19: shared ready/busy low while any die busy
// RULE20: status bit 6 cache ready, 5 done
// RULE21: interleaved dies use enhanced status only
// RULE22: program before read, read data out first
// RULE23: feature 90h value 01h enters otp mode
// RULE24: feature 90h value 00h leaves otp modes
// RULE25: otp mode held until exit value written; here any value other than 01h written to 90h leaves it
package nos_pkg;
	localparam int CLK_MHZ = 250;
	localparam int NS_PER_US = 1000;
	localparam int T_WP_NS = 12;
	localparam int T_WH_NS = 10;
	localparam int T_SETUP_NS = 5;
	localparam int T_WB_NS = 100;
	localparam int WP_CYC = (T_WP_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	localparam int WH_CYC = (T_WH_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	localparam int WB_CYC = (T_WB_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	localparam int SYNC_LAT = 3;
	localparam int CNT_W = 8;

	localparam logic [7:0] CMD_READ_SETUP = 8'h00;
	localparam logic [7:0] CMD_READ_GO = 8'h30;
	localparam logic [7:0] CMD_CACHE_SEQ = 8'h31;
	localparam logic [7:0] CMD_READ_PLANE = 8'h32;
	localparam logic [7:0] CMD_CACHE_END = 8'h3F;
	localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
	localparam logic [7:0] CMD_COL_IN = 8'h85;
	localparam logic [7:0] CMD_PROG_GO = 8'h10;
	localparam logic [7:0] CMD_PROG_PLANE = 8'h11;
	localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
	localparam logic [7:0] CMD_ERASE_PLANE = 8'hD1;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] CMD_ID = 8'h90;
	localparam logic [7:0] CMD_ID_B = 8'hEC;
	localparam logic [7:0] CMD_ID_C = 8'hED;
	localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
	localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
	localparam logic [7:0] FEAT_OTP = 8'h90;
	localparam logic [7:0] P1_EXIT = 8'h00;
	localparam logic [7:0] P1_OTP = 8'h01;
	localparam logic [7:0] P1_PROTECT = 8'h03;
	localparam logic [7:0] OTP_PAGE_MIN = 8'h02;
	localparam logic [7:0] OTP_PAGE_MAX = 8'h1E;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [1:0] FEAT_LAST = 2'h3;

	localparam logic [2:0] COL_CYC = 3'h2;
	localparam logic [2:0] ROW_CYC = 3'h3;
	localparam logic [1:0] ROW_PAGE = 2'h0;
	localparam logic [1:0] ROW_PLANE = 2'h1;
	localparam logic [1:0] ROW_DIE = 2'h2;
	localparam int PLANE_BIT = 0;
	localparam int DIE_BIT = 2;
	localparam int ST_FAIL = 0;
	localparam int ST_CACHED_FAIL_FLAG = 1;

	localparam logic [7:0] OFS_STEP = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_RDATA = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0C;
	localparam int STEP_KIND_LSB = 8;
	localparam int CTRL_CE = 0;
	localparam int STAT_REFUSED = 7;
	localparam int HTRANS_ACT = 1;

	typedef enum logic [1:0] {
		K_CMD = 2'b00,
		K_ADDR = 2'b01,
		K_WR = 2'b10,
		K_RD = 2'b11
	} nos_kind_t;

	typedef enum logic [1:0] {
		PK_READ = 2'b00,
		PK_PROG = 2'b01,
		PK_ERASE = 2'b10
	} nos_pkind_t;

	typedef struct packed {
		nos_kind_t kind;
		logic [7:0] data;
	} nos_step_t;

	typedef struct packed {
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic io_oe;
		logic [7:0] io_out;
	} nos_pins_t;
endpackage

/* File: hdl/nos_sync.sv */
// three-stage pin synchroniser, a bit changes once stages two and three agree
`timescale 1ns/1ns
module nos_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			q_o <= INIT;
		end else begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			q_o <= (q_o & ~(s2 ~^ s3)) | (s2 & (s2 ~^ s3));
		end
	end
endmodule

/* File: hdl/nos_cycle.sv */
// one strobed bus cycle on the nand pins: command, address, data in or data out
`timescale 1ns/1ns
module nos_cycle
	import nos_pkg::*;
#(
	parameter int SETUP_N = SETUP_CYC,
	parameter int LOW_N = WP_CYC,
	parameter int HIGH_N = WH_CYC
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic start_i,
	input wire nos_pkg::nos_step_t step_i,
	input wire logic [7:0] io_sync_i,
	output nos_pkg::nos_pins_t pins_o,
	output logic [7:0] rdata_o,
	output logic done_o,
	output logic busy_o
);
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_SETUP = 2'b01,
		S_LOW = 2'b10,
		S_HIGH = 2'b11
	} nos_cst_t;

	nos_cst_t state;
	logic [CNT_W-1:0] cnt;
	logic is_rd;

	assign busy_o = (state != S_IDLE);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= S_IDLE;
			cnt <= '0;
			is_rd <= 1'b0;
			done_o <= 1'b0;
			rdata_o <= '0;
			pins_o <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, io_oe: 1'b0, io_out: '0};
		end else begin
			done_o <= 1'b0;
			unique case (state)
				S_IDLE: begin
					if (start_i) begin
						is_rd <= (step_i.kind == K_RD);
						pins_o.cle <= (step_i.kind == K_CMD);
						pins_o.ale <= (step_i.kind == K_ADDR);
						pins_o.io_oe <= (step_i.kind != K_RD);
						pins_o.io_out <= step_i.data;
						cnt <= CNT_W'(SETUP_N);
						state <= S_SETUP;
					end
				end
				S_SETUP: begin
					if (cnt <= 1) begin
						pins_o.we_n <= is_rd;
						pins_o.re_n <= !is_rd;
						// read low phase also covers the pin synchroniser delay
						cnt <= is_rd ? CNT_W'(LOW_N + SYNC_LAT) : CNT_W'(LOW_N);
						state <= S_LOW;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				S_LOW: begin
					if (cnt <= 1) begin
						if (is_rd) begin
							rdata_o <= io_sync_i; // [RULE13]
						end
						pins_o.we_n <= 1'b1;
						pins_o.re_n <= 1'b1;
						cnt <= CNT_W'(HIGH_N);
						state <= S_HIGH;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				S_HIGH: begin
					if (cnt <= 1) begin
						pins_o.cle <= 1'b0;
						pins_o.ale <= 1'b0;
						pins_o.io_oe <= 1'b0;
						done_o <= 1'b1;
						state <= S_IDLE;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
			endcase
		end
	end
endmodule

/* File: hdl/nos_host.sv */
// host-side nand sequencer: ahb-lite step register, sequence checking, pin engine
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
module nos_host #(
	parameter int ADDR_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic hsel_i,
	input wire logic [ADDR_W-1:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic rb_n_i,
	input wire logic [7:0] nand_io_i,
	output logic nand_ce_n_o,
	output logic nand_cle_o,
	output logic nand_ale_o,
	output logic nand_we_n_o,
	output logic read_strobe_n_o,
	output logic [7:0] nand_io_o,
	output logic nand_io_oe_o
);
	import nos_pkg::*;

	logic pend, pend_wr;
	logic [7:0] pend_addr;
	logic [31:0] rd_mux;
	logic stall, step_go, refuse, issue;
	nos_step_t step;
	logic rb, eng_busy, eng_done;
	logic [7:0] io_sync, eng_rdata;
	nos_pins_t pins;
	logic ce_en;
	logic [2:0] addr_idx, row_off, ridx;
	logic in_row;
	logic [7:0] cur_setup;
	logic prog_open;
	logic [7:0] row_cur [ROW_CYC];
	logic [7:0] row_ref [ROW_CYC];
	logic plane_saved, multi_plane;
	nos_pkind_t plane_kind, step_pk;
	logic feat_open;
	logic [7:0] feat_addr, p1;
	logic [1:0] par_idx;
	logic otp_mode, prot_mode;
	logic interleaved, hold_block, rd_pending;
	logic [CNT_W-1:0] hold_cnt;
	logic last_rd_step, stat_pending;
	logic [7:0] status_byte;
	logic need_enh, refused;
	logic is_setup;

	nos_sync #(.W(1), .INIT(1'b1)) u_rb_sync (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i(rb_n_i),
		.q_o(rb)
	);

	nos_sync #(.W(8), .INIT(8'h00)) u_io_sync (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i(nand_io_i),
		.q_o(io_sync)
	);

	nos_cycle u_cycle (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.start_i(issue),
		.step_i(step),
		.io_sync_i(io_sync),
		.pins_o(pins),
		.rdata_o(eng_rdata),
		.done_o(eng_done),
		.busy_o(eng_busy)
	);

	assign nand_cle_o = pins.cle;
	assign nand_ale_o = pins.ale;
	assign nand_we_n_o = pins.we_n;
	assign read_strobe_n_o = pins.re_n;
	assign nand_io_o = pins.io_out;
	assign nand_io_oe_o = pins.io_oe;

	// bus slave: one wait state at least, a step write stalls while a pin cycle runs
	assign stall = pend && pend_wr && (pend_addr == OFS_STEP) && eng_busy;
	assign step_go = pend && pend_wr && (pend_addr == OFS_STEP) && !eng_busy;
	assign step.kind = nos_kind_t'(hwdata_i[STEP_KIND_LSB +: 2]);
	assign step.data = hwdata_i[7:0];
	assign issue = step_go && !refuse;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (pend_addr)
			OFS_STATUS: rd_mux[9:0] = {plane_saved, rd_pending, refused, need_enh,
				hold_block, interleaved, prot_mode, otp_mode, rb, eng_busy};
			OFS_RDATA: rd_mux[7:0] = status_byte;
			OFS_CTRL: rd_mux[CTRL_CE] = ce_en;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pend <= 1'b0;
			pend_wr <= 1'b0;
			pend_addr <= '0;
			hreadyout_o <= 1'b1;
			hrdata_o <= 32'h0000_0000;
			hresp_o <= 1'b0;
		end else if (hsel_i && htrans_i[HTRANS_ACT] && hready_i) begin
			pend <= 1'b1;
			pend_wr <= hwrite_i;
			pend_addr <= haddr_i[7:0];
			hreadyout_o <= 1'b0;
		end else if (pend && !stall) begin
			pend <= 1'b0;
			hreadyout_o <= 1'b1;
			hrdata_o <= rd_mux;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ce_en <= 1'b0;
			nand_ce_n_o <= 1'b1;
		end else begin
			if (pend && pend_wr && pend_addr == OFS_CTRL) begin
				ce_en <= hwdata_i[CTRL_CE];
			end
			nand_ce_n_o <= !ce_en;
		end
	end

	// sequence checking on the step about to go out
	assign ridx = addr_idx - row_off;
	assign in_row = (addr_idx >= row_off) && (ridx < ROW_CYC);
	assign is_setup = (step.data == CMD_READ_SETUP) || (step.data == CMD_PROG_SETUP) ||
		(step.data == CMD_ERASE_SETUP);

	always_comb begin
		step_pk = PK_READ;
		if (step.data == CMD_PROG_SETUP) begin
			step_pk = PK_PROG;
		end else if (step.data == CMD_ERASE_SETUP) begin
			step_pk = PK_ERASE;
		end
	end

	always_comb begin
		refuse = 1'b0;
		if (step.kind == K_CMD) begin
			case (step.data)
				CMD_COL_IN: refuse = !prog_open; // [RULE1]
				CMD_STATUS: refuse = interleaved; // [RULE21]
				CMD_STATUS_ENH: refuse = otp_mode || prot_mode; // [RULE7]
				CMD_CACHE_SEQ, CMD_CACHE_END: refuse = otp_mode || prot_mode; // [RULE11]
				default: refuse = 1'b0;
			endcase
			if (is_setup) begin
				if (need_enh) begin
					refuse = 1'b1; // [RULE15]
				end
				if (!rb && hold_block) begin
					refuse = 1'b1; // [RULE18]
				end
				if (plane_saved && step_pk != plane_kind) begin
					refuse = 1'b1; // [RULE14]
				end
				if (step.data == CMD_PROG_SETUP && rd_pending) begin
					refuse = 1'b1; // [RULE22]
				end
			end
		end else if (step.kind == K_ADDR && in_row) begin
			if (otp_mode && cur_setup != CMD_ERASE_SETUP) begin
				if (ridx == 3'(ROW_PAGE)) begin
					refuse = step.data < OTP_PAGE_MIN || step.data > OTP_PAGE_MAX; // [RULE2]
				end else begin
					refuse = step.data != ZERO_BYTE; // [RULE9]
				end
			end
			if (prot_mode && cur_setup == CMD_PROG_SETUP && step.data != ZERO_BYTE) begin
				refuse = 1'b1; // [RULE4]
			end
			if (plane_saved) begin
				if (ridx == 3'(ROW_PAGE) && step.data != row_ref[ROW_PAGE]) begin
					refuse = 1'b1; // [RULE16]
				end
				if (ridx == 3'(ROW_PLANE) &&
					step.data[PLANE_BIT] == row_ref[ROW_PLANE][PLANE_BIT]) begin
					refuse = 1'b1; // [RULE16]
				end
				if (ridx == 3'(ROW_DIE) && step.data[DIE_BIT] != row_ref[ROW_DIE][DIE_BIT]) begin
					refuse = 1'b1; // [RULE16]
				end
			end
		end else if (step.kind == K_WR && prot_mode && prog_open && !feat_open) begin
			refuse = step.data != ZERO_BYTE; // [RULE4]
		end
	end

	// address counting and the open program setup
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			addr_idx <= '0;
			row_off <= COL_CYC;
			cur_setup <= CMD_READ_SETUP;
			prog_open <= 1'b0;
			for (int i = 0; i < ROW_CYC; i++) begin
				row_cur[i] <= '0;
			end
		end else if (issue && step.kind == K_CMD) begin
			addr_idx <= '0;
			if (is_setup) begin
				cur_setup <= step.data;
				row_off <= (step.data == CMD_ERASE_SETUP) ? 3'h0 : COL_CYC;
				prog_open <= (step.data == CMD_PROG_SETUP);
			end else if (step.data != CMD_COL_IN) begin
				prog_open <= 1'b0; // [RULE1]
			end
		end else if (issue && step.kind == K_ADDR) begin
			if (addr_idx != '1) begin
				addr_idx <= addr_idx + 1'b1;
			end
			if (in_row) begin
				row_cur[ridx[1:0]] <= step.data;
			end
		end
	end

	// two-plane bookkeeping: the first plane's row is kept for comparison
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			plane_saved <= 1'b0;
			multi_plane <= 1'b0;
			plane_kind <= PK_READ;
			for (int i = 0; i < ROW_CYC; i++) begin
				row_ref[i] <= '0;
			end
		end else if (issue && step.kind == K_CMD) begin
			case (step.data)
				CMD_READ_PLANE, CMD_PROG_PLANE, CMD_ERASE_PLANE: begin
					plane_saved <= 1'b1;
					plane_kind <= (cur_setup == CMD_PROG_SETUP) ? PK_PROG :
						(cur_setup == CMD_ERASE_SETUP) ? PK_ERASE : PK_READ; // [RULE14]
					row_ref <= row_cur;
				end
				CMD_READ_GO, CMD_PROG_GO, CMD_PROG_CACHE, CMD_ERASE_GO: begin
					multi_plane <= plane_saved && (cur_setup != CMD_READ_SETUP);
					plane_saved <= 1'b0;
				end
				CMD_RESET: plane_saved <= 1'b0;
				default: ;
			endcase
		end
	end

	// feature writes steer the otp modes, which persist until the next write to feature 90h
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			feat_open <= 1'b0;
			feat_addr <= '0;
			par_idx <= '0;
			p1 <= '0;
			otp_mode <= 1'b0;
			prot_mode <= 1'b0;
		end else if (issue) begin
			if (step.kind == K_CMD) begin
				feat_open <= (step.data == CMD_SET_FEAT);
				par_idx <= '0;
			end else if (step.kind == K_ADDR && feat_open) begin
				feat_addr <= step.data;
			end else if (step.kind == K_WR && feat_open) begin
				par_idx <= par_idx + 1'b1;
				if (par_idx == '0) begin
					p1 <= step.data;
				end
				if (par_idx == FEAT_LAST) begin
					feat_open <= 1'b0;
					if (feat_addr == FEAT_OTP) begin
						otp_mode <= (p1 == P1_OTP); // [RULE23] [RULE24] [RULE25]
						prot_mode <= (p1 == P1_PROTECT); // [RULE3] [RULE24]
					end
				end
			end
		end
	end

	// die interleaving: blocked after reset/id/config until the shared busy line is high
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			interleaved <= 1'b0;
			hold_block <= 1'b0;
			hold_cnt <= '0;
		end else begin
			if (issue && step.kind == K_CMD && (step.data == CMD_RESET ||
				step.data == CMD_ID || step.data == CMD_ID_B || step.data == CMD_ID_C ||
				step.data == CMD_GET_FEAT || step.data == CMD_SET_FEAT)) begin
				hold_block <= 1'b1; // [RULE18]
				hold_cnt <= CNT_W'(WB_CYC);
			end else if (issue && hold_block) begin
				// busy may only fall some time after the last cycle, so wait it out
				hold_cnt <= CNT_W'(WB_CYC);
			end else if (hold_cnt != '0) begin
				hold_cnt <= hold_cnt - 1'b1;
			end else if (rb) begin
				hold_block <= 1'b0; // [RULE18]
			end
			if (issue && step.kind == K_CMD && step.data == CMD_RESET) begin
				interleaved <= 1'b0;
			end else if (issue && is_setup && step.kind == K_CMD && !rb) begin
				interleaved <= 1'b1; // [RULE17]
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_pending <= 1'b0;
		end else if (issue && step.kind == K_CMD && step.data == CMD_READ_GO) begin
			rd_pending <= 1'b1; // [RULE22]
		end else if (issue && step.kind == K_RD) begin
			rd_pending <= 1'b0;
		end
	end

	// status capture; the hardware set of a flag wins over its clear
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			last_rd_step <= 1'b0;
			stat_pending <= 1'b0;
			status_byte <= '0;
			need_enh <= 1'b0;
			refused <= 1'b0;
		end else begin
			if (issue) begin
				last_rd_step <= (step.kind == K_RD);
			end
			if (issue && step.kind == K_CMD) begin
				stat_pending <= (step.data == CMD_STATUS);
			end
			if (eng_done && last_rd_step) begin
				status_byte <= eng_rdata; // [RULE8]
			end
			if (eng_done && last_rd_step && stat_pending && multi_plane &&
				(eng_rdata[ST_FAIL] || eng_rdata[ST_CACHED_FAIL_FLAG])) begin
				need_enh <= 1'b1; // [RULE15]
			end else if (issue && step.kind == K_CMD && step.data == CMD_STATUS_ENH) begin
				need_enh <= 1'b0;
			end
			if (step_go && refuse) begin
				refused <= 1'b1;
			end else if (pend && pend_wr && pend_addr == OFS_STATUS &&
				hwdata_i[STAT_REFUSED]) begin
				refused <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	property p_col_in;
		step_go && step.kind == K_CMD && step.data == CMD_COL_IN && prog_open
			|=> ##[1:40] nand_cle_o;
	endproperty
	a_col_in: assert property (p_col_in) else $error("column input refused in program"); // [RULE1]

	property p_page_range;
		step_go && step.kind == K_ADDR && otp_mode && in_row && ridx == 3'h0 &&
			cur_setup != CMD_ERASE_SETUP && step.data > OTP_PAGE_MAX |=> refused && !eng_busy;
	endproperty
	a_page_range: assert property (p_page_range) else $error("otp page out of range"); // [RULE2]

	property p_no_enh_otp;
		step_go && step.kind == K_CMD && step.data == CMD_STATUS_ENH && otp_mode
			|=> refused && !nand_cle_o;
	endproperty
	a_no_enh_otp: assert property (p_no_enh_otp) else $error("enhanced status in otp"); // [RULE7]

	property p_no_cache_otp;
		step_go && step.kind == K_CMD && step.data == CMD_CACHE_SEQ && (otp_mode || prot_mode)
			|=> !eng_busy;
	endproperty
	a_no_cache_otp: assert property (p_no_cache_otp) else $error("cache read in otp"); // [RULE11]

	property p_plane_kind;
		step_go && step.kind == K_CMD && is_setup && plane_saved && step_pk != plane_kind
			|=> refused && !eng_busy;
	endproperty
	a_plane_kind: assert property (p_plane_kind) else $error("mixed plane kinds"); // [RULE14]

	property p_hold;
		hold_block && !rb && step_go && step.kind == K_CMD && is_setup |=> !eng_busy;
	endproperty
	a_hold: assert property (p_hold) else $error("interleave before dies ready"); // [RULE18]

	property p_no_plain_status;
		interleaved && step_go && step.kind == K_CMD && step.data == CMD_STATUS |=> !eng_busy;
	endproperty
	a_no_plain_status: assert property (p_no_plain_status) else $error("plain status"); // [RULE21]

	property p_read_first;
		rd_pending && step_go && step.kind == K_CMD && step.data == CMD_PROG_SETUP
			|=> !eng_busy ##1 !nand_cle_o;
	endproperty
	a_read_first: assert property (p_read_first) else $error("program before read"); // [RULE22]

	property p_enter_otp;
		issue && step.kind == K_WR && feat_open && par_idx == FEAT_LAST &&
			feat_addr == FEAT_OTP && p1 == P1_OTP |=> otp_mode && !prot_mode;
	endproperty
	a_enter_otp: assert property (p_enter_otp) else $error("otp mode not entered"); // [RULE23]

	property p_enh_needed;
		need_enh && step_go && step.kind == K_CMD && is_setup |=> refused;
	endproperty
	a_enh_needed: assert property (p_enh_needed) else $error("no enhanced status"); // [RULE15]

	c_otp_entry: cover property (issue && step.kind == K_WR && par_idx == FEAT_LAST &&
		feat_addr == FEAT_OTP);
	c_refuse: cover property (step_go && refuse);
	c_plane: cover property (issue && step.kind == K_CMD && step.data == CMD_PROG_PLANE);
	c_interleave: cover property ($rose(interleaved));
endmodule

/* File: verification/nos_dev.sv */
// behavioural nand target: otp modes, busy timing, status and sequential page data
`timescale 1ns/1ns
module nos_dev (
	input wire logic clk_i,
	input wire logic ce_n_i,
	input wire logic cle_i,
	input wire logic ale_i,
	input wire logic we_n_i,
	input wire logic re_n_i,
	input wire logic [7:0] io_i,
	output logic [7:0] io_o,
	output logic rb_n_o
);
	int busy = 0;
	int na = 0;
	int nf = 0;
	logic [7:0] cmd = 8'h00;
	logic [7:0] col = 8'h00;
	logic [7:0] p1 = 8'h00;
	logic [7:0] drv = 8'h00;
	logic [1:0] mode = 2'h0; // kept until the next value written to feature 90h
	logic locked = 1'b0;
	// one count stands for every die, so the shared pin stays low while any is busy
	assign rb_n_o = (busy == 0);
	// a released bus shows the inverse of the last byte, never a held value
	assign io_o = re_n_i ? ~drv : drv;
	always @(posedge clk_i) if (busy > 0) busy <= busy - 1;
	always @(posedge we_n_i) if (!ce_n_i) begin
		if (cle_i) begin
			cmd = io_i;
			na = 0;
			nf = 0;
			if (io_i == 8'h30) busy = 100;
			if (io_i == 8'hD0) busy = 200;
			if (io_i == 8'h10) busy = (mode == 2'h3 && locked) ? 20 : 150;
			if (io_i == 8'h10 && mode == 2'h3) locked = 1'b1;
		end else if (ale_i) begin
			if (na == 0) col = io_i;
			na++;
		end else begin
			if (nf == 0) p1 = io_i;
			nf++;
			if (cmd == 8'hEF && col == 8'h90 && nf == 4) mode = p1[1:0];
		end
	end
	always @(negedge re_n_i) if (!ce_n_i) begin
		// bit6 cache ready and bit5 done follow the pin, bit0 reports pass
		drv = (cmd == 8'h70) ? {1'b0, rb_n_o, rb_n_o, 5'h00} : col;
		if (cmd != 8'h70) col++;
	end
endmodule

/* File: verification/nos_host_test.sv */
// self-checking bench: ahb steps, otp modes, refusals, interleaved dies
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
	$display("unexpected at %0t: %h %h", $time, a, b); end end
module nos_host_test;
	import nos_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [7:0] haddr = 8'h00;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata, s;
	logic hrdy, ce_n, cle, ale, we_n, re_n, oe, rb_n;
	logic [7:0] io_o, dev_io, c;
	logic [7:0] bad[3] = '{CMD_COL_IN, CMD_STATUS_ENH, CMD_CACHE_SEQ};
	logic [9:0] q[$];
	logic [9:0] e;
	int error_cnt = 0;
	int compares = 0;
	wire logic [7:0] io_w = oe ? io_o : dev_io;
	nos_host dut (.clk_i(clk_i), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(), .rb_n_i(rb_n),
		.nand_io_i(io_w), .nand_ce_n_o(ce_n), .nand_cle_o(cle), .nand_ale_o(ale),
		.nand_we_n_o(we_n), .read_strobe_n_o(re_n), .nand_io_o(io_o), .nand_io_oe_o(oe));
	nos_dev dev (.clk_i(clk_i), .ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
		.re_n_i(re_n), .io_i(io_w), .io_o(dev_io), .rb_n_o(rb_n));
	initial forever #2 clk_i = ~clk_i;
	// every write-strobed pin cycle must match the next accepted command, address or data-in step, refused ones never show
	always @(posedge we_n) if (rst_b && !ce_n) begin
		e = q.size() ? q.pop_front() : 10'h3FF;
		`CHK({cle, ale, io_o}, e)
	end
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tick;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hrdy !== 1'b1 && n < 500);
		if (n >= 500) begin
			error_cnt++;
			close_out();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		tick();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		tick();
		s = hrdata;
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0000_0000);
		`CHK(s, x)
	endtask
	task automatic step(input nos_kind_t k, input logic [7:0] b);
		if (k != K_RD) q.push_back({k == K_CMD, k == K_ADDR, b});
		bus(1'b1, OFS_STEP, {22'h00_0000, k, b});
	endtask
	task automatic wait_st(input int b, input logic v);
		int n;
		n = 0;
		do begin
			bus(1'b0, OFS_STATUS, 32'h0000_0000);
			n++;
		end while ((s[0] !== 1'b0 || s[b] !== v) && n < 400);
		if (n >= 400) begin
			error_cnt++;
			close_out();
		end
	endtask
	task automatic st_bit(input int b, input logic v);
		wait_st(0, 1'b0);
		`CHK(s[b], v)
	endtask
	task automatic done;
		wait_st(1, 1'b0);
		wait_st(1, 1'b1);
	endtask
	task automatic rd_byte(input logic [7:0] x);
		step(K_RD, 8'h00);
		wait_st(0, 1'b0);
		chk_rd(OFS_RDATA, {24'h00_0000, x});
	endtask
	task automatic feat(input logic [7:0] p);
		step(K_CMD, CMD_SET_FEAT);
		step(K_ADDR, FEAT_OTP);
		step(K_WR, p);
		repeat (3) step(K_WR, ZERO_BYTE);
	endtask
	task automatic refuse(input nos_kind_t k, input logic [7:0] b);
		step(k, b);
		void'(q.pop_back());
		st_bit(STAT_REFUSED, 1'b1);
		bus(1'b1, OFS_STATUS, 32'h0000_0080);
	endtask
	task automatic addr5(input logic [7:0] c0, input logic [7:0] pg);
		logic [7:0] a[5];
		a = '{c0, 8'h00, pg, 8'h00, 8'h00};
		foreach (a[i]) step(K_ADDR, a[i]);
	endtask
	task automatic prog(input logic [7:0] pg, input logic [7:0] d, input logic go);
		step(K_CMD, CMD_PROG_SETUP);
		addr5(8'h00, pg);
		step(K_WR, d);
		if (go) begin
			step(K_CMD, CMD_PROG_GO);
			done();
			step(K_CMD, CMD_STATUS);
			rd_byte(8'h60);
		end
	endtask
	task automatic rdpage(input logic [7:0] c0, input logic [7:0] pg);
		step(K_CMD, CMD_READ_SETUP);
		addr5(c0, pg);
		step(K_CMD, CMD_READ_GO);
		done();
		refuse(K_CMD, CMD_PROG_SETUP);
		for (int i = 0; i < 3; i++) rd_byte(c0 + 8'(i));
	endtask
	task automatic erase(input logic [7:0] die);
		step(K_CMD, CMD_ERASE_SETUP);
		step(K_ADDR, 8'h00);
		step(K_ADDR, 8'h00);
		step(K_ADDR, die);
	endtask
	initial begin
		void'($urandom(27346));
		repeat (10) @(posedge clk_i);
		rst_b <= 1'b1;
		for (int i = 1; i < 5; i++) chk_rd(8'(4 * i), (i == 1) ? 32'h0000_0002 : 32'h0000_0000);
		bus(1'b1, OFS_CTRL, 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		`CHK(ce_n, 1'b0)
		$display("test reset done");
		feat(P1_OTP);
		st_bit(2, 1'b1);
		foreach (bad[i]) refuse(K_CMD, bad[i]);
		c = 8'($urandom_range(0, 200));
		prog(8'h05, 8'($urandom()), 1'b0);
		repeat (2) begin
			step(K_CMD, CMD_COL_IN);
			step(K_ADDR, c);
			step(K_ADDR, 8'h00);
			step(K_WR, 8'($urandom()));
		end
		step(K_CMD, CMD_PROG_GO);
		done();
		step(K_CMD, CMD_STATUS);
		rd_byte(8'h60);
		step(K_CMD, CMD_PROG_SETUP);
		step(K_ADDR, 8'h00);
		step(K_ADDR, 8'h00);
		refuse(K_ADDR, 8'h1F);
		step(K_CMD, CMD_RESET);
		$display("test otp program done");
		rdpage(c, 8'h05);
		feat(P1_PROTECT);
		st_bit(3, 1'b1);
		repeat (2) prog(ZERO_BYTE, ZERO_BYTE, 1'b1);
		st_bit(3, 1'b1);
		feat(P1_OTP);
		rdpage(c, 8'h1E);
		feat(P1_EXIT);
		st_bit(2, 1'b0);
		st_bit(3, 1'b0);
		$display("test otp protect done");
		step(K_CMD, CMD_PROG_SETUP);
		addr5(8'h00, 8'h07);
		step(K_CMD, CMD_PROG_PLANE);
		refuse(K_CMD, CMD_ERASE_SETUP);
		step(K_CMD, CMD_PROG_SETUP);
		repeat (2) step(K_ADDR, 8'h00);
		step(K_ADDR, 8'h07);
		refuse(K_ADDR, 8'h00);
		step(K_ADDR, 8'h01);
		step(K_ADDR, 8'h00);
		step(K_CMD, CMD_RESET);
		// the config hold must lapse first, or the first erase keeps it up until all dies idle
		wait_st(5, 1'b0);
		erase(8'h00);
		step(K_CMD, CMD_ERASE_GO);
		wait_st(1, 1'b0);
		wait_st(5, 1'b0);
		erase(8'h04);
		st_bit(4, 1'b1);
		step(K_CMD, CMD_ERASE_GO);
		refuse(K_CMD, CMD_STATUS);
		step(K_CMD, CMD_RESET);
		refuse(K_CMD, CMD_READ_SETUP);
		wait_st(1, 1'b1);
		st_bit(4, 1'b0);
		`CHK(q.size(), 0)
		$display("test interleave done");
		close_out();
	end
endmodule
